// [common/dual_sar_params.svh]
`ifndef DUAL_SAR_PARAMS_SVH
`define DUAL_SAR_PARAMS_SVH

// configuration word layout
`define CFG_WIDTH 12
`define CFG_LAST_BIT 4'hb
`define CFG_CHAN_HI 11
`define CFG_CHAN_LO 10
`define CFG_FEAT_HI 9
`define CFG_FEAT_LO 8
`define CFG_DEEP_PD 7
`define CFG_NAP 6
`define CFG_AUTONAP 5
`define CFG_REF_OFF 4
`define CFG_SPECIAL_READ 3
`define CFG_CMD_HI 2
`define CFG_CMD_LO 0

// reset values
`define CHAN_RESET_VALUE 2'h0
`define DAC_RESET_VALUE 10'h3ff

// field codes
`define FEAT_UPDATE 2'h1
`define CMD_DAC_WRITE 3'h1
`define CMD_DAC_READ 3'h3
`define CMD_SOFT_RESET 3'h5
`define CHAN_PAIR0 2'h0
`define CHAN_PAIR1_NEG 2'h1
`define CHAN_PAIR1_POS 2'h2
`define CHAN_PAIR1 2'h3

// timing counts in clock cycles, and the first SAR trial code
`define CONVERT_CYCLES 12
`define LAST_CONVERT_STEP 4'hb
`define MIN_ACQ_CYCLES 2'h2
`define MIN_CYCLE_CLOCKS 16
`define SAR_START_CODE 12'h800

`endif

// [common/dual_sar_pkg.sv]
`include "dual_sar_params.svh"

package dual_sar_pkg;

  typedef enum logic [1:0] {st_acquire, st_convert, st_precharge} seq_state_e;

  typedef enum logic [1:0] {
    pos_pair0_positive,
    pos_pair1_negative,
    pos_pair1_positive
  } pos_route_e;

  typedef struct packed {
    logic active;
    logic [3:0] count;
    logic [`CFG_WIDTH-1:0] shift;
    logic valid;
    logic [`CFG_WIDTH-1:0] word;
  } shifter_s;

  typedef struct packed {
    seq_state_e state;
    logic start_prev;
    logic [3:0] step;
    logic [1:0] acq_count;
    logic busy;
    logic sample_hold;
    logic precharge_active;
    logic acquire_ready;
    logic [`CFG_WIDTH-1:0] trial_a;
    logic [`CFG_WIDTH-1:0] trial_b;
    logic [`CFG_WIDTH-1:0] result_a;
    logic [`CFG_WIDTH-1:0] result_b;
    logic result_valid;
    logic [1:0] chan;
    pos_route_e pos_route;
    logic neg_pair1;
    logic dac_write_pending;
    logic dac_read_pending;
    logic [9:0] dac_code;
    logic reference_off;
    logic deep_power_down;
    logic nap_enable;
    logic autonap_enable;
    logic special_read;
  } seq_s;

endpackage : dual_sar_pkg

// [hw/config_shifter.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dual_sar_params.svh"

module config_shifter (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic read_strobe,
  input wire logic serial_config_input,
  output logic word_valid,
  output logic [`CFG_WIDTH-1:0] word
);

  dual_sar_pkg::shifter_s cur;
  dual_sar_pkg::shifter_s next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.valid = 1'b0;
    if (!cur.active && read_strobe) begin
      // frame opens on the first edge the strobe is seen; that bit is the msb
      next_cur.active = 1'b1;
      next_cur.count = 4'h1;
      next_cur.shift = {cur.shift[`CFG_WIDTH-2:0], serial_config_input};
    end else if (cur.active) begin
      next_cur.shift = {cur.shift[`CFG_WIDTH-2:0], serial_config_input};
      next_cur.count = cur.count + 4'h1;
      if (cur.count == `CFG_LAST_BIT) begin
        next_cur.active = 1'b0;
        next_cur.valid = 1'b1;
        next_cur.word = {cur.shift[`CFG_WIDTH-2:0], serial_config_input};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign word_valid = cur.valid;
  assign word = cur.word;

endmodule : config_shifter

`default_nettype wire

// [hw/dual_sar_conversion_sequencer.sv]
// What this block does
// - both channels sample together, convert in parallel
// - codes 00 and 11 pick full pairs
// - codes 01, 10 route pair-1 against pair-0 negative
// - channel bits of config word steer both
// - exactly one pre-charge cycle after each conversion
// - busy low throughout acquisition
// - acquisition from pre-charge end to start edge
// - start edge holds inputs, converting follows
// - read strobe acts on first edge seen
// - cycle is twelve, one, two, one clocks
// - power-on reset restores every default
// - command code 101 resets settings
// - ten-bit code sets reference level
// - busy rises at hold, falls at finish
// - twelve-bit word shifted msb first
// - configuration holds zeros after power-up, reference code 3ff
// - results leave as two's complement
`timescale 1ns/100ps
`default_nettype none
`include "dual_sar_params.svh"

module dual_sar_conversion_sequencer #(
  parameter int RESULT_WIDTH = 12,
  parameter int DAC_WIDTH = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conversion_start_strobe,
  input wire logic read_strobe,
  input wire logic serial_config_input,
  input wire logic comparator_a,
  input wire logic comparator_b,
  output logic busy,
  output logic sample_hold,
  output logic precharge_active,
  output logic acquire_ready,
  output logic [1:0] positive_route,
  output logic negative_pair1,
  output logic [RESULT_WIDTH-1:0] trial_code_a,
  output logic [RESULT_WIDTH-1:0] trial_code_b,
  output logic [RESULT_WIDTH-1:0] result_a,
  output logic [RESULT_WIDTH-1:0] result_b,
  output logic result_valid,
  output logic [DAC_WIDTH-1:0] dac_code,
  output logic reference_off,
  output logic deep_power_down,
  output logic nap_enable,
  output logic autonap_enable,
  output logic special_read
);

  if (RESULT_WIDTH != `CONVERT_CYCLES) begin : bad_result_width
    $error("result width must equal the number of conversion steps");
  end
  if (DAC_WIDTH != 10) begin : bad_dac_width
    $error("reference code width is fixed at ten bits");
  end

  dual_sar_pkg::seq_s cur;
  dual_sar_pkg::seq_s next_cur;
  logic cfg_valid;
  logic [`CFG_WIDTH-1:0] cfg_word;

  // one successive-approximation step: settle the bit under trial, try the next
  function automatic logic [`CFG_WIDTH-1:0] sar_step(
    input logic [`CFG_WIDTH-1:0] trial,
    input logic [3:0] step,
    input logic keep
  );
    logic [`CFG_WIDTH-1:0] t;
    logic [3:0] bitpos;
    t = trial;
    bitpos = `LAST_CONVERT_STEP - step;
    t[bitpos] = keep;
    if (bitpos != 4'h0) begin
      t[bitpos - 4'h1] = 1'b1;
    end
    return t;
  endfunction : sar_step

  // positive multiplexer leg from the two channel bits
  function automatic dual_sar_pkg::pos_route_e pos_decode(input logic [1:0] chan);
    dual_sar_pkg::pos_route_e r;
    r = dual_sar_pkg::pos_pair0_positive;
    if (chan == `CHAN_PAIR1_NEG) begin
      r = dual_sar_pkg::pos_pair1_negative;
    end else if (chan == `CHAN_PAIR1_POS || chan == `CHAN_PAIR1) begin
      r = dual_sar_pkg::pos_pair1_positive;
    end
    return r;
  endfunction : pos_decode

  config_shifter u_config_shifter (
    .clk_sys(clk_sys),
    .rst(rst),
    .read_strobe(read_strobe),
    .serial_config_input(serial_config_input),
    .word_valid(cfg_valid),
    .word(cfg_word)
  );

  always_comb begin
    next_cur = cur;
    next_cur.result_valid = 1'b0;
    next_cur.start_prev = conversion_start_strobe;

    case (cur.state)
      dual_sar_pkg::st_acquire: begin
        next_cur.busy = 1'b0;
        next_cur.sample_hold = 1'b0;
        next_cur.precharge_active = 1'b0;
        if (cur.acq_count != `MIN_ACQ_CYCLES) begin
          next_cur.acq_count = cur.acq_count + 2'h1;
        end
        // host is told when the two sampling clocks have passed
        next_cur.acquire_ready = (next_cur.acq_count == `MIN_ACQ_CYCLES);
        if (conversion_start_strobe && !cur.start_prev) begin
          // rising edge ends acquisition and freezes both capacitors at once
          next_cur.state = dual_sar_pkg::st_convert;
          next_cur.sample_hold = 1'b1;
          next_cur.busy = 1'b1;
          next_cur.acquire_ready = 1'b0;
          next_cur.step = 4'h0;
          next_cur.trial_a = `SAR_START_CODE;
          next_cur.trial_b = `SAR_START_CODE;
        end
      end

      dual_sar_pkg::st_convert: begin
        // start edges seen here are ignored; the host must not send them
        next_cur.trial_a = sar_step(cur.trial_a, cur.step, comparator_a);
        next_cur.trial_b = sar_step(cur.trial_b, cur.step, comparator_b);
        next_cur.step = cur.step + 4'h1;
        if (cur.step == `LAST_CONVERT_STEP) begin
          // offset binary to two's complement is an msb flip
          next_cur.result_a = next_cur.trial_a ^ `SAR_START_CODE;
          next_cur.result_b = next_cur.trial_b ^ `SAR_START_CODE;
          next_cur.result_valid = 1'b1;
          next_cur.busy = 1'b0;
          next_cur.sample_hold = 1'b0;
          next_cur.precharge_active = 1'b1;
          next_cur.state = dual_sar_pkg::st_precharge;
        end
      end

      dual_sar_pkg::st_precharge: begin
        // single cycle on the reference, then back to the multiplexer
        next_cur.precharge_active = 1'b0;
        next_cur.acq_count = 2'h0;
        next_cur.acquire_ready = 1'b0;
        next_cur.state = dual_sar_pkg::st_acquire;
      end

      default: begin
        next_cur.state = dual_sar_pkg::st_acquire;
      end
    endcase

    if (cfg_valid) begin
      if (cur.dac_write_pending) begin
        next_cur.dac_code = cfg_word[9:0];
        next_cur.dac_write_pending = 1'b0;
      end else if (cur.dac_read_pending) begin
        // readback path is outside this block; the access is consumed
        next_cur.dac_read_pending = 1'b0;
      end else begin
        next_cur.chan = cfg_word[`CFG_CHAN_HI:`CFG_CHAN_LO];
        if (cfg_word[`CFG_FEAT_HI:`CFG_FEAT_LO] == `FEAT_UPDATE) begin
          next_cur.deep_power_down = cfg_word[`CFG_DEEP_PD];
          next_cur.nap_enable = cfg_word[`CFG_NAP];
          next_cur.autonap_enable = cfg_word[`CFG_AUTONAP];
          next_cur.reference_off = cfg_word[`CFG_REF_OFF];
          next_cur.special_read = cfg_word[`CFG_SPECIAL_READ];
        end
        if (cfg_word[`CFG_CMD_HI:`CFG_CMD_LO] == `CMD_DAC_WRITE) begin
          next_cur.dac_write_pending = 1'b1;
        end else if (cfg_word[`CFG_CMD_HI:`CFG_CMD_LO] == `CMD_DAC_READ) begin
          next_cur.dac_read_pending = 1'b1;
        end else if (cfg_word[`CFG_CMD_HI:`CFG_CMD_LO] == `CMD_SOFT_RESET) begin
          // settings only; a conversion in flight runs to completion
          next_cur.chan = `CHAN_RESET_VALUE;
          next_cur.dac_code = `DAC_RESET_VALUE;
          next_cur.deep_power_down = 1'b0;
          next_cur.nap_enable = 1'b0;
          next_cur.autonap_enable = 1'b0;
          next_cur.reference_off = 1'b0;
          next_cur.special_read = 1'b0;
        end
      end
    end

    next_cur.pos_route = pos_decode(next_cur.chan);
    next_cur.neg_pair1 = (next_cur.chan == `CHAN_PAIR1);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur <= '0;
      cur.state <= dual_sar_pkg::st_acquire;
      cur.chan <= `CHAN_RESET_VALUE;
      cur.pos_route <= dual_sar_pkg::pos_pair0_positive;
      cur.dac_code <= `DAC_RESET_VALUE;
    end else begin
      cur <= next_cur;
    end
  end

  assign busy = cur.busy;
  assign sample_hold = cur.sample_hold;
  assign precharge_active = cur.precharge_active;
  assign acquire_ready = cur.acquire_ready;
  assign positive_route = cur.pos_route;
  assign negative_pair1 = cur.neg_pair1;
  assign trial_code_a = cur.trial_a;
  assign trial_code_b = cur.trial_b;
  assign result_a = cur.result_a;
  assign result_b = cur.result_b;
  assign result_valid = cur.result_valid;
  assign dac_code = cur.dac_code;
  assign reference_off = cur.reference_off;
  assign deep_power_down = cur.deep_power_down;
  assign nap_enable = cur.nap_enable;
  assign autonap_enable = cur.autonap_enable;
  assign special_read = cur.special_read;

endmodule : dual_sar_conversion_sequencer

`default_nettype wire

// [tb/comparator_model.sv]
`timescale 1ns/100ps
`default_nettype none

module comparator_model (
  input wire logic [11:0] trial_code_a,
  input wire logic [11:0] trial_code_b,
  input wire logic [11:0] target_a,
  input wire logic [11:0] target_b,
  output logic comparator_a,
  output logic comparator_b
);
  // ideal comparators, no noise: final trial lands exactly on target
  assign comparator_a = (trial_code_a <= target_a);
  assign comparator_b = (trial_code_b <= target_b);
endmodule : comparator_model

`default_nettype wire

// [tb/seq_sva.sv]
`timescale 1ns/100ps
`default_nettype none

module seq_sva #(
  parameter int RESULT_WIDTH = 12
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conversion_start_strobe,
  input wire logic busy,
  input wire logic sample_hold,
  input wire logic precharge_active,
  input wire logic acquire_ready,
  input wire logic [RESULT_WIDTH-1:0] result_a,
  input wire logic [RESULT_WIDTH-1:0] result_b,
  input wire logic result_valid
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_convert;
    busy[*8] ##1 busy[*4];
  endsequence
  sequence s_finish;
    !busy && precharge_active && result_valid;
  endsequence

  property p_conv_len;
    $rose(busy) |-> s_convert ##1 s_finish;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_busy_hold;
    busy == sample_hold;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("hold and busy differ");
  property p_precharge;
    $fell(busy) |-> precharge_active ##1 !precharge_active;
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge not one cycle");
  property p_both_done;
    $fell(busy) |-> result_valid;
  endproperty
  a_both_done: assert property (p_both_done) else $error("results late");
  property p_acq_low;
    acquire_ready |-> !busy && !precharge_active;
  endproperty
  a_acq_low: assert property (p_acq_low) else $error("busy during acquisition");
  property p_acq_start;
    $fell(precharge_active) |-> !acquire_ready ##1 !acquire_ready ##1 acquire_ready;
  endproperty
  a_acq_start: assert property (p_acq_start) else $error("acquisition timing wrong");
  property p_start;
    acquire_ready && conversion_start_strobe && !$past(conversion_start_strobe)
      |=> busy && sample_hold;
  endproperty
  a_start: assert property (p_start) else $error("start edge not taken");
  property p_result_stands;
    ($changed(result_a) || $changed(result_b)) |-> result_valid;
  endproperty
  a_result_stands: assert property (p_result_stands) else $error("result moved alone");
endmodule : seq_sva

bind dual_sar_conversion_sequencer seq_sva #(.RESULT_WIDTH(RESULT_WIDTH)) u_sva (
  .clk_sys(clk_sys),
  .rst(rst),
  .conversion_start_strobe(conversion_start_strobe),
  .busy(busy),
  .sample_hold(sample_hold),
  .precharge_active(precharge_active),
  .acquire_ready(acquire_ready),
  .result_a(result_a),
  .result_b(result_b),
  .result_valid(result_valid)
);

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic clk_sys = 1'b0;
  logic clk_run = 1'b1;
  logic rst = 1'b1;
  logic conversion_start_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic serial_config_input = 1'b0;
  logic comparator_a, comparator_b, busy, sample_hold, precharge_active, acquire_ready;
  logic [1:0] positive_route;
  logic negative_pair1, result_valid, reference_off, deep_power_down;
  logic nap_enable, autonap_enable, special_read;
  logic [11:0] trial_code_a, trial_code_b, result_a, result_b;
  logic [11:0] target_a = 12'h000;
  logic [11:0] target_b = 12'h000;
  logic [9:0] dac_code;
  int fails = 0;
  int total_checks = 0;

  dual_sar_conversion_sequencer u_dut (
    .clk_sys(clk_sys), .rst(rst), .conversion_start_strobe(conversion_start_strobe),
    .read_strobe(read_strobe), .serial_config_input(serial_config_input),
    .comparator_a(comparator_a), .comparator_b(comparator_b), .busy(busy),
    .sample_hold(sample_hold), .precharge_active(precharge_active),
    .acquire_ready(acquire_ready), .positive_route(positive_route),
    .negative_pair1(negative_pair1), .trial_code_a(trial_code_a),
    .trial_code_b(trial_code_b), .result_a(result_a), .result_b(result_b),
    .result_valid(result_valid), .dac_code(dac_code), .reference_off(reference_off),
    .deep_power_down(deep_power_down), .nap_enable(nap_enable),
    .autonap_enable(autonap_enable), .special_read(special_read)
  );
  comparator_model u_cmp (
    .trial_code_a(trial_code_a), .trial_code_b(trial_code_b), .target_a(target_a),
    .target_b(target_b), .comparator_a(comparator_a), .comparator_b(comparator_b)
  );

  // 10 MHz, inside the allowed host clock range
  // host may park the clock low between transfers; it never stops high
  initial begin
    forever begin
      #50;
      if (clk_run || clk_sys) begin
        clk_sys = ~clk_sys;
      end
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one frame, msb first; strobe only on the opening edge
  task automatic send_cfg(input logic [11:0] w);
    for (int i = 11; i >= 0; i--) begin
      read_strobe = (i == 11);
      serial_config_input = w[i];
      @(negedge clk_sys);
    end
    read_strobe = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : send_cfg

  task automatic wait_ready;
    int n;
    n = 0;
    // start only once acquisition is ready, never while busy
    while (acquire_ready !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 100) begin
      fails++;
      give_verdict();
    end
  endtask : wait_ready

  task automatic convert(input logic [11:0] ta, input logic [11:0] tb_v);
    int n;
    int b;
    target_a = ta;
    target_b = tb_v;
    wait_ready();
    conversion_start_strobe = 1'b1;
    @(negedge clk_sys);
    conversion_start_strobe = 1'b0;
    b = 0;
    n = 0;
    while (result_valid !== 1'b1 && n < 40) begin
      if (busy === 1'b1) b++;
      @(negedge clk_sys);
      n++;
    end
    if (n >= 40) begin
      fails++;
      give_verdict();
    end
    chk("busy_cycles", 12'(12), 12'(b));
    chk("result_a", ta ^ 12'h800, result_a);
    chk("result_b", tb_v ^ 12'h800, result_b);
    chk("precharge_on", 12'h001, {11'h000, precharge_active});
    @(negedge clk_sys);
    chk("precharge_off", 12'h000, {11'h000, precharge_active});
  endtask : convert

  task automatic test_reset;
    chk("dac_reset", 12'h3ff, {2'h0, dac_code});
    chk("route_reset", 12'h000, {9'h000, positive_route, negative_pair1});
    chk("feat_reset", 12'h000, {7'h00, deep_power_down, nap_enable, autonap_enable,
      reference_off, special_read});
    $display("test_reset done");
  endtask : test_reset

  task automatic test_routes;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      send_cfg({c, 10'h000});
      chk("positive_route", {10'h000, (c == 2'h3) ? 2'h2 : c}, {10'h000, positive_route});
      chk("negative_pair1", {11'h000, c == 2'h3}, {11'h000, negative_pair1});
    end
    $display("test_routes done");
  endtask : test_routes

  task automatic test_features;
    send_cfg(12'h1a8);
    chk("features_set", 12'h015, {7'h00, deep_power_down, nap_enable, autonap_enable,
      reference_off, special_read});
    // enable field 00 must leave the features alone
    send_cfg(12'h050);
    chk("features_kept", 12'h015, {7'h00, deep_power_down, nap_enable, autonap_enable,
      reference_off, special_read});
    send_cfg(12'h001);
    send_cfg(12'h2a5);
    // parked after the 14th edge, the reference code must already have landed
    clk_run = 1'b0;
    #525;
    chk("dac_parked", 12'h2a5, {2'h0, dac_code});
    clk_run = 1'b1;
    @(negedge clk_sys);
    chk("dac_write", 12'h2a5, {2'h0, dac_code});
    send_cfg(12'h005);
    chk("soft_dac", 12'h3ff, {2'h0, dac_code});
    chk("soft_feat", 12'h000, {7'h00, deep_power_down, nap_enable, autonap_enable,
      reference_off, special_read});
    $display("test_features done");
  endtask : test_features

  task automatic test_convert;
    // back-to-back at minimum spacing, boundary codes
    convert(12'h000, 12'hfff);
    convert(12'h7ff, 12'h800);
    // two more edges reach the 16th; the clock may then rest low
    repeat (2) @(negedge clk_sys);
    clk_run = 1'b0;
    #525;
    chk("parked_state", 12'h002, {10'h000, acquire_ready, busy});
    chk("parked_result", 12'hfff, result_a);
    clk_run = 1'b1;
    @(negedge clk_sys);
    convert(12'h5a3, 12'h2c4);
    $display("test_convert done");
  endtask : test_convert

  task automatic test_combined;
    logic [11:0] w;
    w = 12'hc00;
    target_a = 12'h123;
    target_b = 12'hedc;
    wait_ready();
    // strobes tied: one pulse starts a conversion and opens a frame
    for (int i = 11; i >= 0; i--) begin
      read_strobe = (i == 11);
      conversion_start_strobe = (i == 11);
      serial_config_input = w[i];
      @(negedge clk_sys);
      if (i == 11) begin
        chk("tied_busy", 12'h001, {11'h000, busy});
      end
    end
    read_strobe = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("tied_route", 12'h005, {9'h000, positive_route, negative_pair1});
    chk("tied_result_a", 12'h923, result_a);
    chk("tied_result_b", 12'h6dc, result_b);
    $display("test_combined done");
  endtask : test_combined

  initial begin
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    test_reset();
    test_routes();
    test_features();
    test_convert();
    test_combined();
    give_verdict();
  end
endmodule : tb

`default_nettype wire
